// ===== rtl/liu_ctrl.sv
// line interface control, clock recovery, attenuator fifo and status
`timescale 1ns/1ps
module liu_ctrl #(
  parameter int UNDER_CYCLES = liu_pkg::UNDER_CYC,
  parameter int FIFO_BITS = 128
) (
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // axi4-lite write address, data and response
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // master clock tick and line-rate reference
  input wire logic mclkTick,
  // receive line, sampled levels from the slicer
  input wire logic rxLinePos,
  input wire logic rxLineNeg,
  input wire logic [3:0] rxLevelMeas,
  // analog transmit driver monitors
  input wire logic txOverCurrent,
  input wire logic txOpenSense,
  // transmit backplane
  input wire logic txClockIn,
  input wire logic txPosDataIn,
  input wire logic txNegDataIn,
  // receive backplane
  output logic rxLineClockPin,
  output logic rxPosDataOut,
  output logic rxNegDataOut,
  // transmit line
  output logic txLinePos,
  output logic txLineNeg,
  output logic txLineOe,
  // analog controls
  output logic txCurrentLimitEn,
  output logic [1:0] rxTermSel,
  output logic rxGainLimit,
  output logic [5:0] monitorBoostDb,
  output logic [2:0] buildoutSelect,
  output logic lineStdE1,
  output logic attenClockFromPll
);
  import liu_pkg::*;

  localparam int PW = $clog2(FIFO_BITS);

  typedef struct packed {
    logic awDone;
    logic wDone;
    logic [7:0] awAddr;
    logic [31:0] wData;
    logic [3:0] wStrb;
    logic bValid;
    logic [1:0] bResp;
    logic rValid;
    logic [31:0] rData;
    logic [1:0] rResp;
    logic [7:0] lineCtrlOne;
    logic [7:0] lineCtrlTwo;
    logic [7:0] lineCtrlThree;
    logic [7:0] lineCtrlFour;
    logic [7:0] commonCtrlFour;
    logic [7:0] statusRegOne;
    logic [7:0] irqMaskOne;
    logic [3:0] syncRx;
    logic [2:0] syncTx;
    logic txClkLast;
    logic [3:0] preCnt;
    logic lineTick;
    logic [4:0] ovsCnt;
    logic [4:0] ovsLimit;
    logic [7:0] silentCnt;
    logic carrierLoss;
    logic attenRun;
    logic [31:0] underCnt;
    logic violArmed;
    logic violLast;
    logic [1:0] onesRun;
    logic lastMarkPos;
    logic [FIFO_BITS-1:0] fifoPos;
    logic [FIFO_BITS-1:0] fifoNeg;
    logic [PW:0] wrPtr;
    logic [PW:0] rdPtr;
    logic outClk;
    logic outPos;
    logic outNeg;
    logic linePos;
    logic lineNeg;
    logic lineOe;
  } liu_state_t;

  liu_state_t s_r, s_nxt;

  function automatic logic [7:0] merge(input logic [7:0] cur, input logic [31:0] d,
                                       input logic [3:0] st);
    merge = st[0] ? d[7:0] : cur;
  endfunction

  function automatic logic [3:0] prediv(input logic [2:0] sel);
    case (sel)
      MC_16M: prediv = DIV_16M;
      MC_8M: prediv = DIV_8M;
      MC_4M: prediv = DIV_4M;
      default: prediv = DIV_1;
    endcase
  endfunction

  logic [PW:0] fill;
  logic [7:0] depth;
  logic [7:0] margin;
  logic e1, attenOn, attenTx, syncRxClk, txEdge, bitStrobe;
  logic inPos, inNeg, popReq, pushReq;
  logic [7:0] setEv;

  always_comb begin
    s_nxt = s_r;
    e1 = s_r.lineCtrlTwo[B_STD];
    attenOn = ~s_r.lineCtrlOne[B_ADIS];
    attenTx = s_r.lineCtrlOne[B_APLACE];
    depth = s_r.lineCtrlOne[B_ADEPTH] ? DEPTH_SHALLOW : DEPTH_DEEP;
    margin = s_r.lineCtrlOne[B_ADEPTH] ? MARGIN_SHALLOW : MARGIN_DEEP;
    fill = s_r.wrPtr - s_r.rdPtr;
    setEv = 8'h00;
    // reading starts once the fifo has filled to its centre, so it runs half full
    if (!attenOn) begin
      s_nxt.attenRun = 1'b0;
    end else if ({{(7-PW){1'b0}}, fill} >= {1'b0, depth[7:1]}) begin
      s_nxt.attenRun = 1'b1;
    end
    syncRxClk = e1 & s_r.lineCtrlThree[B_RXSYNC];
    // third stage only is read
    txEdge = s_r.syncTx[2] & ~s_r.txClkLast;
    // two stages per leg: [1] positive, [3] negative are the settled copies
    s_nxt.syncRx = {s_r.syncRx[2], rxLineNeg, s_r.syncRx[0], rxLinePos};
    s_nxt.syncTx = {s_r.syncTx[1], s_r.syncTx[0], txClockIn};
    s_nxt.txClkLast = s_r.syncTx[2];

    // prescaler to line rate
    s_nxt.lineTick = 1'b0;
    if (mclkTick) begin
      if (s_r.preCnt + 4'h1 >= prediv(s_r.lineCtrlFour[B_MCSEL +: 3])) begin
        s_nxt.preCnt = 4'h0;
        s_nxt.lineTick = 1'b1;
      end else begin
        s_nxt.preCnt = s_r.preCnt + 4'h1;
      end
    end

    // oversampling bit counter; limit shifts to 15 or 17 near fifo limits
    bitStrobe = 1'b0;
    s_nxt.ovsCnt = s_r.ovsCnt + 5'h1;
    if (s_r.ovsCnt + 5'h1 >= s_r.ovsLimit) begin
      s_nxt.ovsCnt = 5'h0;
      bitStrobe = 1'b1;
    end
    s_nxt.ovsLimit = OVS_NOM;
    if (attenOn && {{(7-PW){1'b0}}, fill} + margin >= depth) begin
      s_nxt.ovsLimit = OVS_FAST;
      setEv[B_ST_TRIP] = 1'b1;
    end else if (attenOn && {{(7-PW){1'b0}}, fill} < {1'b0, margin[7:1]} && s_r.attenRun) begin
      s_nxt.ovsLimit = OVS_SLOW;
      setEv[B_ST_TRIP] = 1'b1;
    end

    // carrier detect on the synchronised receive pair
    if (s_r.lineTick) begin
      if (s_r.syncRx[1] | s_r.syncRx[3]) begin
        s_nxt.silentCnt = 8'h00;
      end else if (s_r.silentCnt != LOS_BITS) begin
        s_nxt.silentCnt = s_r.silentCnt + 8'h01;
      end
    end
    s_nxt.carrierLoss = (s_r.silentCnt == LOS_BITS) & ~syncRxClk;

    // level threshold persistence
    if ({1'b0, rxLevelMeas} < s_r.commonCtrlFour[4:0]) begin
      if (s_r.underCnt >= UNDER_CYCLES - 1) begin
        setEv[B_ST_UNDER] = 1'b1;
      end else begin
        s_nxt.underCnt = s_r.underCnt + 32'h1;
      end
    end else begin
      s_nxt.underCnt = 32'h0;
    end

    if (txOverCurrent) setEv[B_ST_SHORT] = 1'b1;
    if (txOpenSense) setEv[B_ST_OPEN] = 1'b1;

    // fifo: push side clock, pop side smoothed strobe
    inPos = attenTx ? txPosDataIn : s_r.syncRx[1];
    inNeg = attenTx ? txNegDataIn : s_r.syncRx[3];
    pushReq = attenTx ? txEdge : s_r.lineTick;
    popReq = bitStrobe & s_r.attenRun;
    if (attenOn && pushReq && fill != depth[PW:0]) begin
      s_nxt.fifoPos[s_r.wrPtr[PW-1:0]] = inPos;
      s_nxt.fifoNeg[s_r.wrPtr[PW-1:0]] = inNeg;
      s_nxt.wrPtr = s_r.wrPtr + 1'b1;
    end
    if (attenOn && popReq && fill != 0) begin
      s_nxt.rdPtr = s_r.rdPtr + 1'b1;
    end

    // receive backplane outputs
    if (s_r.carrierLoss) begin
      s_nxt.outClk = s_r.lineTick ? ~s_r.outClk : s_r.outClk;
      s_nxt.outPos = 1'b0;
      s_nxt.outNeg = 1'b0;
    end else if (attenOn && !attenTx) begin
      s_nxt.outClk = s_r.ovsCnt < {1'b0, s_r.ovsLimit[4:1]};
      s_nxt.outPos = s_r.fifoPos[s_r.rdPtr[PW-1:0]];
      s_nxt.outNeg = s_r.fifoNeg[s_r.rdPtr[PW-1:0]];
    end else begin
      s_nxt.outClk = s_r.lineTick;
      if (s_r.lineTick) begin
        s_nxt.outPos = s_r.syncRx[1];
        s_nxt.outNeg = s_r.syncRx[3];
      end
    end

    // violation insertion arms on a rising control bit
    s_nxt.violLast = s_r.lineCtrlTwo[B_VIOL];
    if (s_r.lineCtrlTwo[B_VIOL] && !s_r.violLast) s_nxt.violArmed = 1'b1;

    // transmit line, advanced per transmit clock edge, or toggled per line tick in e1 transmit sync mode
    if (txEdge) begin
      if (txPosDataIn | txNegDataIn) begin
        s_nxt.onesRun = (s_r.onesRun == 2'h3) ? 2'h3 : s_r.onesRun + 2'h1;
      end else begin
        s_nxt.onesRun = 2'h0;
      end
      s_nxt.linePos = txPosDataIn;
      s_nxt.lineNeg = txNegDataIn;
      if ((txPosDataIn | txNegDataIn) && s_r.onesRun >= 2'h2 && s_r.violArmed) begin
        s_nxt.linePos = s_r.lastMarkPos;
        s_nxt.lineNeg = ~s_r.lastMarkPos;
        s_nxt.violArmed = 1'b0;
      end else if (txPosDataIn | txNegDataIn) begin
        s_nxt.lastMarkPos = txPosDataIn;
      end
      if (attenOn && attenTx) begin
        s_nxt.linePos = s_r.fifoPos[s_r.rdPtr[PW-1:0]];
        s_nxt.lineNeg = s_r.fifoNeg[s_r.rdPtr[PW-1:0]];
      end
    end
    if (e1 && s_r.lineCtrlThree[B_TXSYNC]) begin
      s_nxt.linePos = s_r.lineTick ? ~s_r.linePos : s_r.linePos;
      s_nxt.lineNeg = 1'b0;
    end
    s_nxt.lineOe = s_r.lineCtrlOne[B_PWR];
    if (!s_r.lineCtrlOne[B_PWR]) begin
      s_nxt.linePos = 1'b0;
      s_nxt.lineNeg = 1'b0;
    end
    s_nxt.statusRegOne = s_r.statusRegOne | setEv;

    // axi write channel
    if (s_axi_awvalid && !s_r.awDone) begin
      s_nxt.awDone = 1'b1;
      s_nxt.awAddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !s_r.wDone) begin
      s_nxt.wDone = 1'b1;
      s_nxt.wData = s_axi_wdata;
      s_nxt.wStrb = s_axi_wstrb;
    end
    // readies stay low until the response is taken: one write at a time
    if (s_r.bValid && s_axi_bready) begin
      s_nxt.bValid = 1'b0;
      s_nxt.awDone = 1'b0;
      s_nxt.wDone = 1'b0;
    end
    if (s_r.awDone && s_r.wDone && !s_r.bValid) begin
      s_nxt.bValid = 1'b1;
      s_nxt.bResp = RESP_OKAY;
      case (s_r.awAddr)
        OFF_CTRL_ONE: s_nxt.lineCtrlOne = merge(s_r.lineCtrlOne, s_r.wData, s_r.wStrb);
        OFF_CTRL_TWO: s_nxt.lineCtrlTwo = merge(s_r.lineCtrlTwo, s_r.wData, s_r.wStrb);
        OFF_CTRL_THREE: s_nxt.lineCtrlThree = merge(s_r.lineCtrlThree, s_r.wData, s_r.wStrb);
        OFF_CTRL_FOUR: s_nxt.lineCtrlFour = merge(s_r.lineCtrlFour, s_r.wData, s_r.wStrb);
        OFF_COMMON_FOUR: s_nxt.commonCtrlFour = merge(s_r.commonCtrlFour, s_r.wData,
                                                      s_r.wStrb) & 8'h1F;
        OFF_MASK_ONE: s_nxt.irqMaskOne = merge(s_r.irqMaskOne, s_r.wData, s_r.wStrb);
        OFF_STATUS_ONE: begin
          // write one to clear; a set this cycle survives
          if (s_r.wStrb[0]) s_nxt.statusRegOne = (s_r.statusRegOne & ~s_r.wData[7:0]) | setEv;
        end
        OFF_INFO_TWO: ;
        default: s_nxt.bResp = RESP_SLVERR;
      endcase
    end

    // axi read channel
    if (s_r.rValid && s_axi_rready) s_nxt.rValid = 1'b0;
    if (s_axi_arvalid && !s_r.rValid) begin
      s_nxt.rValid = 1'b1;
      s_nxt.rResp = RESP_OKAY;
      s_nxt.rData = 32'h0;
      case (s_axi_araddr)
        OFF_CTRL_ONE: s_nxt.rData[7:0] = s_r.lineCtrlOne;
        OFF_CTRL_TWO: s_nxt.rData[7:0] = s_r.lineCtrlTwo;
        OFF_CTRL_THREE: s_nxt.rData[7:0] = s_r.lineCtrlThree;
        OFF_CTRL_FOUR: s_nxt.rData[7:0] = s_r.lineCtrlFour;
        OFF_COMMON_FOUR: s_nxt.rData[7:0] = s_r.commonCtrlFour;
        OFF_MASK_ONE: s_nxt.rData[7:0] = s_r.irqMaskOne;
        OFF_STATUS_ONE: s_nxt.rData[7:0] = s_r.statusRegOne;
        // live level, open, limiter/short, carrier loss
        OFF_INFO_TWO: s_nxt.rData[7:0] = {s_r.carrierLoss, 1'b0, txOverCurrent,
                                          txOpenSense, rxLevelMeas};
        default: s_nxt.rResp = RESP_SLVERR;
      endcase
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      s_r <= '0;
      s_r.ovsLimit <= OVS_NOM;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign s_axi_awready = ~s_r.awDone;
  assign s_axi_wready = ~s_r.wDone;
  assign s_axi_bvalid = s_r.bValid;
  assign s_axi_bresp = s_r.bResp;
  assign s_axi_arready = ~s_r.rValid;
  assign s_axi_rvalid = s_r.rValid;
  assign s_axi_rdata = s_r.rData;
  assign s_axi_rresp = s_r.rResp;
  assign rxLineClockPin = s_r.outClk;
  assign rxPosDataOut = s_r.outPos;
  assign rxNegDataOut = s_r.outNeg;
  assign txLinePos = s_r.linePos;
  assign txLineNeg = s_r.lineNeg;
  assign txLineOe = s_r.lineOe;
  assign txCurrentLimitEn = ~s_r.lineCtrlTwo[B_SLD];
  assign rxTermSel = s_r.lineCtrlFour[B_TERM +: 2];
  assign rxGainLimit = s_r.lineCtrlOne[B_GLIM];
  assign monitorBoostDb = (s_r.lineCtrlThree[B_MON +: 2] == 2'h0) ? 6'h00 :
                          (s_r.lineCtrlThree[B_MON +: 2] == 2'h1) ? 6'h14 :
                          (s_r.lineCtrlThree[B_MON +: 2] == 2'h2) ? 6'h1A : 6'h20;
  assign buildoutSelect = s_r.lineCtrlOne[B_BUILD +: 3];
  assign lineStdE1 = s_r.lineCtrlTwo[B_STD];
  assign attenClockFromPll = s_r.lineCtrlTwo[B_AMUX];
endmodule

// ===== rtl/liu_pkg.sv
// shared constants for the line interface digital control block
package liu_pkg;
  // register byte offsets
  localparam logic [7:0] OFF_CTRL_ONE = 8'h00;
  localparam logic [7:0] OFF_CTRL_TWO = 8'h04;
  localparam logic [7:0] OFF_CTRL_THREE = 8'h08;
  localparam logic [7:0] OFF_CTRL_FOUR = 8'h0C;
  localparam logic [7:0] OFF_COMMON_FOUR = 8'h10;
  localparam logic [7:0] OFF_INFO_TWO = 8'h14;
  localparam logic [7:0] OFF_STATUS_ONE = 8'h18;
  localparam logic [7:0] OFF_MASK_ONE = 8'h1C;
  // line_ctrl_one fields
  localparam int B_PWR = 0;
  localparam int B_ADIS = 1;
  localparam int B_ADEPTH = 2;
  localparam int B_APLACE = 3;
  localparam int B_GLIM = 4;
  localparam int B_BUILD = 5;
  // line_ctrl_two fields
  localparam int B_SLD = 1;
  localparam int B_AMUX = 3;
  localparam int B_VIOL = 5;
  localparam int B_STD = 7;
  // line_ctrl_three fields
  localparam int B_TXSYNC = 1;
  localparam int B_RXSYNC = 2;
  localparam int B_MON = 3;
  // line_ctrl_four fields
  localparam int B_TERM = 0;
  localparam int B_MCSEL = 4;
  // status_reg_one fields
  localparam int B_ST_OPEN = 1;
  localparam int B_ST_SHORT = 2;
  localparam int B_ST_TRIP = 4;
  localparam int B_ST_UNDER = 7;
  // reset values
  localparam logic [7:0] RST_CTRL = 8'h00;
  // master clock selection codes
  localparam logic [2:0] MC_16M = 3'h0;
  localparam logic [2:0] MC_8M = 3'h1;
  localparam logic [2:0] MC_4M = 3'h2;
  localparam logic [2:0] MC_2M = 3'h3;
  localparam logic [2:0] MC_1M5 = 3'h4;
  // prescale ratios
  localparam logic [3:0] DIV_16M = 4'h8;
  localparam logic [3:0] DIV_8M = 4'h4;
  localparam logic [3:0] DIV_4M = 4'h2;
  localparam logic [3:0] DIV_1 = 4'h1;
  // oversampling
  localparam logic [4:0] OVS_NOM = 5'h10;
  localparam logic [4:0] OVS_FAST = 5'h0F;
  localparam logic [4:0] OVS_SLOW = 5'h11;
  localparam logic [7:0] DEPTH_DEEP = 8'h80;
  localparam logic [7:0] DEPTH_SHALLOW = 8'h20;
  localparam logic [7:0] MARGIN_DEEP = 8'h04;
  localparam logic [7:0] MARGIN_SHALLOW = 8'h02;
  // carrier loss: this many silent line bits
  localparam logic [7:0] LOS_BITS = 8'hC0;
  // timing
  localparam int CLK_MHZ = 200;
  localparam int UNDER_MS = 50;
  localparam int UNDER_CYC = UNDER_MS * CLK_MHZ * 1000;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// ===== tb/liu_ctrl_props.sv
// concurrent checks on the line interface control block ports
`timescale 1ns/1ps
module liu_ctrl_props #(
  parameter int UNDER_CYCLES = 100,
  parameter int FIFO_BITS = 128
) (
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // register bus
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // transmit line and analog controls
  input wire logic txLinePos,
  input wire logic txLineNeg,
  input wire logic txLineOe,
  input wire logic [5:0] monitorBoostDb
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);
  // a powered-down driver must never show a mark on either leg
  a_off_line_quiet: assert property (!txLineOe |-> !txLinePos && !txLineNeg)
    else $error("line driven while output disabled");
  a_monitor_codes: assert property (monitorBoostDb inside {6'h00, 6'h14, 6'h1A, 6'h20})
    else $error("monitor boost outside legal set");
  a_b_stands: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  a_r_stands: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped early");
  a_ar_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address accepted while answer pending");
  a_r_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  a_b_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid &&
    s_axi_wready |-> ##[1:3] s_axi_bvalid)
    else $error("write answer late");
  a_w_refused: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write accepted while response pending");
  c_write: cover property (s_axi_bvalid && s_axi_bready);
  c_read: cover property (s_axi_rvalid && s_axi_rready);
  c_driving: cover property (txLineOe && txLinePos);
  c_boost_max: cover property (monitorBoostDb == 6'h20);
endmodule
bind liu_ctrl liu_ctrl_props #(.UNDER_CYCLES(UNDER_CYCLES), .FIFO_BITS(FIFO_BITS)) chk (.*);

// ===== tb/liu_line_model.sv
// line and framer side: master clock ticks, transmit clock and ami marks
`timescale 1ns/1ps
module liu_line_model (
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // traffic on or silent line
  input wire logic lineEn,
  // outputs toward the block
  output logic mclkTick,
  output logic txClockIn,
  output logic txPosDataIn,
  output logic txNegDataIn,
  output logic rxLinePos,
  output logic rxLineNeg
);
  logic [6:0] divCnt;
  logic markSel;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      mclkTick <= 1'b0;
      txClockIn <= 1'b0;
      divCnt <= 7'h00;
      markSel <= 1'b0;
      txPosDataIn <= 1'b0;
      txNegDataIn <= 1'b0;
      rxLinePos <= 1'b0;
      rxLineNeg <= 1'b0;
    end else begin
      mclkTick <= ~mclkTick;
      divCnt <= (divCnt == 7'h30) ? 7'h00 : divCnt + 7'h01;
      // steady clock, never gapped: the attenuator stays on the receive side
      if (divCnt == 7'h30) begin
        txClockIn <= ~txClockIn;
      end
      // data moves on the falling clock edge so it is stable at the rising one
      if (divCnt == 7'h30 && txClockIn) begin
        markSel <= ~markSel;
        txPosDataIn <= lineEn && !markSel;
        txNegDataIn <= lineEn && markSel;
        rxLinePos <= lineEn && !markSel;
        rxLineNeg <= lineEn && markSel;
      end
    end
  end
endmodule

// ===== tb/liu_ctrl_tb.sv
// self-checking bench for the line interface control block
`timescale 1ns/1ps
module liu_ctrl_tb;
  import liu_pkg::*;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00;
  logic [7:0] s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'b0;
  logic s_axi_wvalid = 1'b0;
  logic s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0;
  logic s_axi_rready = 1'b0;
  logic [3:0] rxLevelMeas = 4'h0;
  logic txOverCurrent = 1'b0;
  logic txOpenSense = 1'b0;
  logic lineEn = 1'b0;
  logic mclkTick, txClockIn, txPosDataIn, txNegDataIn, rxLinePos, rxLineNeg;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, rxTermSel, rr;
  logic [31:0] s_axi_rdata, rv;
  logic rxLineClockPin, rxPosDataOut, rxNegDataOut, txLinePos, txLineNeg, txLineOe;
  logic txCurrentLimitEn, rxGainLimit, lineStdE1, attenClockFromPll;
  logic [5:0] monitorBoostDb;
  logic [2:0] buildoutSelect;
  int nErrors = 0;
  int numChecks = 0;
  int txMarks = 0;
  always #2.5 clk = ~clk;
  always @(posedge txLinePos) txMarks = txMarks + 1;
  // a mark held past one bit time means two marks of one polarity: a violation
  int runCnt = 0;
  int viols = 0;
  logic runNeg = 1'b0;
  always @(posedge clk) begin
    if (!(txLinePos | txLineNeg) || txLineNeg != runNeg) begin
      runCnt <= 0;
    end else begin
      runCnt <= runCnt + 1;
    end
    runNeg <= txLineNeg;
    if (runCnt == 150) viols <= viols + 1;
  end
  // short under-threshold count keeps the run brief
  liu_ctrl #(.UNDER_CYCLES(100)) uut (.*);
  liu_line_model line (.*);
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    numChecks++;
    if (s !== e) begin
      $display("unexpected %s expected %h seen %h", n, e, s);
      nErrors++;
    end
  endtask
  // ready and answers are read at the falling edge, settled before the taking edge
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic ta, tw, tb, dn;
    dn = 1'b0;
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!dn) begin
      @(negedge clk);
      ta = s_axi_awvalid && s_axi_awready;
      tw = s_axi_wvalid && s_axi_wready;
      tb = s_axi_bvalid;
      rr = s_axi_bresp;
      @(posedge clk);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
      if (tb) begin
        s_axi_bready <= 1'b0;
        dn = 1'b1;
      end
    end
  endtask
  task automatic rd(input logic [7:0] a);
    logic ta, tr, dn;
    dn = 1'b0;
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    while (!dn) begin
      @(negedge clk);
      ta = s_axi_arvalid && s_axi_arready;
      tr = s_axi_rvalid;
      rv = s_axi_rdata;
      rr = s_axi_rresp;
      @(posedge clk);
      if (ta) s_axi_arvalid <= 1'b0;
      if (tr) begin
        s_axi_rready <= 1'b0;
        dn = 1'b1;
      end
    end
  endtask
  task automatic testReset();
    logic [7:0] offs [6] = '{OFF_CTRL_ONE, OFF_CTRL_TWO, OFF_CTRL_THREE, OFF_CTRL_FOUR,
      OFF_STATUS_ONE, OFF_MASK_ONE};
    chk("oe after reset", 32'(txLineOe), 32'h0);
    foreach (offs[i]) begin
      rd(offs[i]);
      chk("reset value", rv, 32'(RST_CTRL));
    end
    $display("reset test done");
  endtask
  task automatic testCtrl();
    logic [5:0] boost [4] = '{6'h00, 6'h14, 6'h1A, 6'h20};
    // standard first, buildout after it
    wr(OFF_CTRL_TWO, 32'h80 | (32'h1 << B_AMUX) | (32'h1 << B_SLD));
    wr(OFF_CTRL_ONE, (32'h5 << B_BUILD) | (32'h1 << B_GLIM) | 32'h1);
    wr(OFF_CTRL_FOUR, 32'h2 | (32'(MC_2M) << B_MCSEL));
    repeat (3) @(posedge clk);
    chk("e1 select", 32'(lineStdE1), 32'h1);
    chk("atten mux", 32'(attenClockFromPll), 32'h1);
    chk("limit off", 32'(txCurrentLimitEn), 32'h0);
    chk("buildout", 32'(buildoutSelect), 32'h5);
    chk("gain limit", 32'(rxGainLimit), 32'h1);
    chk("termination", 32'(rxTermSel), 32'h2);
    chk("oe on", 32'(txLineOe), 32'h1);
    rd(OFF_CTRL_ONE);
    chk("ctrl one", rv, 32'hB1);
    for (int m = 0; m < 4; m++) begin
      wr(OFF_CTRL_THREE, 32'(m) << B_MON);
      repeat (2) @(posedge clk);
      chk("monitor boost", 32'(monitorBoostDb), 32'(boost[m]));
    end
    wr(OFF_CTRL_TWO, 32'h0);
    // external termination: both select bits zero
    wr(OFF_CTRL_FOUR, 32'(MC_2M) << B_MCSEL);
    repeat (3) @(posedge clk);
    chk("t1 select", 32'(lineStdE1), 32'h0);
    chk("mux bypass", 32'(attenClockFromPll), 32'h0);
    chk("limit on", 32'(txCurrentLimitEn), 32'h1);
    chk("term zero", 32'(rxTermSel), 32'h0);
    wr(8'h40, 32'h1);
    chk("unmapped write", 32'(rr), 32'(RESP_SLVERR));
    rd(8'h40);
    chk("unmapped read", 32'(rr), 32'(RESP_SLVERR));
    $display("control test done");
  endtask
  task automatic testStatus();
    rxLevelMeas <= 4'hA;
    txOverCurrent <= 1'b1;
    txOpenSense <= 1'b1;
    repeat (4) @(posedge clk);
    rd(OFF_INFO_TWO);
    chk("info live", rv & 32'h7F, 32'h3A);
    txOverCurrent <= 1'b0;
    txOpenSense <= 1'b0;
    repeat (4) @(posedge clk);
    rd(OFF_INFO_TWO);
    chk("info idle", rv & 32'h7F, 32'h0A);
    rd(OFF_STATUS_ONE);
    chk("latched", rv & 32'h06, 32'h06);
    wr(OFF_STATUS_ONE, 32'h06);
    rd(OFF_STATUS_ONE);
    chk("cleared", rv & 32'h06, 32'h0);
    // threshold 12 steps sits above the level of 10
    wr(OFF_COMMON_FOUR, 32'h0C);
    rd(OFF_STATUS_ONE);
    chk("under early", rv & 32'h80, 32'h0);
    repeat (120) @(posedge clk);
    rd(OFF_STATUS_ONE);
    chk("under set", rv & 32'h80, 32'h80);
    rxLevelMeas <= 4'hF;
    repeat (4) @(posedge clk);
    rd(OFF_STATUS_ONE);
    chk("under held", rv & 32'h80, 32'h80);
    $display("status test done");
  endtask
  task automatic testLine();
    // line has been silent since reset
    repeat (8000) @(posedge clk);
    rd(OFF_INFO_TWO);
    chk("carrier lost", rv & 32'h80, 32'h80);
    wr(OFF_CTRL_ONE, 32'hB1 | (32'h1 << B_ADEPTH));
    lineEn <= 1'b1;
    repeat (5000) @(posedge clk);
    rd(OFF_INFO_TWO);
    chk("carrier back", rv & 32'h80, 32'h0);
    chk("marks sent", 32'(txMarks > 0), 32'h1);
    chk("no violation", 32'(viols), 32'h0);
    wr(OFF_CTRL_TWO, 32'h1 << B_VIOL);
    repeat (1500) @(posedge clk);
    chk("one violation", 32'(viols), 32'h1);
    wr(OFF_CTRL_ONE, 32'h0);
    repeat (3) @(posedge clk);
    chk("oe off", 32'(txLineOe), 32'h0);
    $display("line test done");
  endtask
  task automatic stopTest();
    $display("checks %0d mismatches %0d", numChecks, nErrors);
    if (nErrors == 0 && numChecks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  initial begin
    repeat (40000) @(posedge clk);
    nErrors++;
    stopTest();
  end
  initial begin
    repeat (10) @(posedge clk);
    resetn <= 1'b1;
    testReset();
    testCtrl();
    testStatus();
    testLine();
    stopTest();
  end
endmodule
